// ### inc/tcu_map.svh
// Register offsets, field positions, reset values and counts of the timer
`ifndef TCU_MAP_SVH
`define TCU_MAP_SVH
`define TCU_OFS_MODE    8'h00
`define TCU_OFS_CAPCTL  8'h04
`define TCU_OFS_PRESC   8'h08
`define TCU_OFS_OUTCTL  8'h0C
`define TCU_OFS_COUNT   8'h10
`define TCU_OFS_CCA     8'h14
`define TCU_OFS_CCB     8'h18
`define TCU_OFS_IRQST   8'h1C
`define TCU_OFS_IRQMSK  8'h20
`define TCU_CAP_A_EN    0
`define TCU_CAP_A_OPP   1
`define TCU_CAP_B_EN    2
`define TCU_PRE_SEL_LO  0
`define TCU_EDGE_A_LO   4
`define TCU_EDGE_B_LO   6
`define TCU_OUT_EN      0
`define TCU_OUT_MODE_LO 1
`define TCU_OUT_MODE_HI 2
`define TCU_OUT_LVS     3
`define TCU_OUT_LVR     4
`define TCU_IRQ_A       0
`define TCU_IRQ_B       1
`define TCU_IRQ_OVF     2
`define TCU_DIV_SEL1    8'h02
`define TCU_DIV_SEL2    8'h08
`define TCU_DIV_SEL3    8'h20
`define TCU_RST_WORD    32'h0000_0000
`endif

// ### inc/tcu_pkg.sv
// Types shared by the timer capture/compare unit
package tcu_pkg;
    typedef enum logic [1:0] {
        TCU_STOP,
        TCU_FREE_RUN,
        TCU_CLR_ON_PIN,
        TCU_CLR_ON_MATCH
    } tcu_mode_t;
    typedef enum logic [1:0] {
        TCU_EDGE_FALL,
        TCU_EDGE_RISE,
        TCU_EDGE_NONE,
        TCU_EDGE_BOTH
    } tcu_edge_t;
    typedef enum logic [1:0] {
        TCU_PRE_DIV1,
        TCU_PRE_DIV2,
        TCU_PRE_DIV3,
        TCU_PRE_PIN_A
    } tcu_presc_t;
endpackage : tcu_pkg

// ### core/tcu_edge_det.sv
// Valid-edge and opposite-edge detector for one trigger pin
`timescale 1ns/1ns
module tcu_edge_det
    import tcu_pkg::*;
(
    // Clock and reset
    input  wire logic      clock_i,
    input  wire logic      sys_rst_i,
    // Pin and control
    input  wire logic      pin_i,
    input  wire logic      run_i,
    input  wire logic      rearm_i,
    input  wire tcu_edge_t edge_sel_i,
    // Detected edges
    output logic           valid_o,
    output logic           opp_o
);
    logic prev_ff;
    logic rise;
    logic fall;

    // Before the first start a high pin looks like a rising edge;
    // after a stop the pin level is tracked so no edge is invented
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            prev_ff <= 1'b0;
        end else if (!run_i) begin
            prev_ff <= rearm_i ? pin_i : 1'b0;
        end else begin
            prev_ff <= pin_i;
        end
    end

    assign rise = run_i & pin_i & ~prev_ff;
    assign fall = run_i & ~pin_i & prev_ff;

    // Opposite edge is the valid edge with the sense swapped
    always_comb begin
        unique case (edge_sel_i)
            TCU_EDGE_FALL: begin
                valid_o = fall;
                opp_o   = rise;
            end
            TCU_EDGE_RISE: begin
                valid_o = rise;
                opp_o   = fall;
            end
            TCU_EDGE_NONE: begin
                valid_o = 1'b0;
                opp_o   = 1'b0;
            end
            TCU_EDGE_BOTH: begin
                valid_o = rise | fall;
                opp_o   = rise | fall;
            end
        endcase
    end
endmodule : tcu_edge_det

// ### core/tcu_timer.sv
// 16-bit timer/event counter with two capture/compare registers
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "tcu_map.svh"

module tcu_timer
    import tcu_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Trigger pins
    input  wire logic        trigger_pin_a_i,
    input  wire logic        trigger_pin_b_i,
    // Timer output pin, enable active low
    output logic             timer_output_pin_o,
    output logic             timer_output_oe_n_o,
    // Interrupt
    output logic             irq_o
);
    logic [1:0]  mode_ff;
    logic [2:0]  capctl_ff;
    logic [7:0]  presc_ff;
    logic [2:0]  outctl_ff;
    logic [15:0] count_ff;
    logic [15:0] cap_cmp_reg_a_ff;
    logic [15:0] cap_cmp_reg_b_ff;
    logic [2:0]  irq_st_ff;
    logic [2:0]  irq_msk_ff;
    logic [7:0]  div_ff;
    logic        started_once_ff;
    logic        out_level_ff;
    logic [31:0] rdata_ff;

    logic        wr;
    logic        rd_setup;
    logic        mapped;
    logic        run;
    tcu_mode_t   mode;
    tcu_presc_t  presc;
    logic        edge_a;
    logic        opp_a;
    logic        edge_b;
    logic        tick;
    logic [7:0]  div_lim;
    logic        match_a;
    logic        match_b;
    logic        clr_cnt;
    logic        cap_a;
    logic        cap_b;
    logic        ppg_on;
    logic [2:0]  irq_set;
    logic [2:0]  irq_clr;
    logic [2:0]  nxt_irq_st;

    assign mode   = tcu_mode_t'(mode_ff);
    assign presc  = tcu_presc_t'(presc_ff[`TCU_PRE_SEL_LO +: 2]);
    assign run    = (mode != TCU_STOP);
    assign ppg_on = outctl_ff[`TCU_OUT_MODE_HI];

    // Bus decode; every slot answers at once
    assign wr       = psel_i & penable_i & pwrite_i;
    assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
    always_comb begin
        unique case (paddr_i)
            `TCU_OFS_MODE, `TCU_OFS_CAPCTL, `TCU_OFS_PRESC,
            `TCU_OFS_OUTCTL, `TCU_OFS_COUNT, `TCU_OFS_CCA,
            `TCU_OFS_CCB, `TCU_OFS_IRQST, `TCU_OFS_IRQMSK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // Edge detectors for both trigger pins
    tcu_edge_det u_edge_a (
        .clock_i    (clock_i),
        .sys_rst_i  (sys_rst_i),
        .pin_i      (trigger_pin_a_i),
        .run_i      (run),
        .rearm_i    (started_once_ff),
        .edge_sel_i (tcu_edge_t'(presc_ff[`TCU_EDGE_A_LO +: 2])),
        .valid_o    (edge_a),
        .opp_o      (opp_a)
    );
    tcu_edge_det u_edge_b (
        .clock_i    (clock_i),
        .sys_rst_i  (sys_rst_i),
        .pin_i      (trigger_pin_b_i),
        .run_i      (run),
        .rearm_i    (started_once_ff),
        .edge_sel_i (tcu_edge_t'(presc_ff[`TCU_EDGE_B_LO +: 2])),
        .valid_o    (edge_b),
        .opp_o      ()
    );

    // Remember the first start so later starts track the pin level
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            started_once_ff <= 1'b0;
        end else if (run) begin
            started_once_ff <= 1'b1;
        end
    end

    // Count clock select
    always_comb begin
        unique case (presc)
            TCU_PRE_DIV1:  div_lim = `TCU_DIV_SEL1;
            TCU_PRE_DIV2:  div_lim = `TCU_DIV_SEL2;
            TCU_PRE_DIV3:  div_lim = `TCU_DIV_SEL3;
            TCU_PRE_PIN_A: div_lim = 8'h01;
        endcase
    end
    assign tick = (presc == TCU_PRE_PIN_A) ? edge_a
                : (div_ff == div_lim - 8'h01);

    // Prescaler restarts with the timer, so the first tick lags by
    // one full count period after the start
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !run || tick) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // Compare matches only count in compare mode
    assign match_a = run & tick & ~capctl_ff[`TCU_CAP_A_EN]
                   & (count_ff == cap_cmp_reg_a_ff);
    assign match_b = run & tick & ~capctl_ff[`TCU_CAP_B_EN]
                   & (count_ff == cap_cmp_reg_b_ff);

    // Clear sources; pin A edge clears even when it is the count clock
    assign clr_cnt = (mode == TCU_CLR_ON_PIN && edge_a)
                   | ((mode == TCU_CLR_ON_MATCH || ppg_on)
                      && match_a);

    // Counter stops and reads zero while the mode field is 00
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !run) begin
            count_ff <= 16'h0000;
        end else if (clr_cnt) begin
            count_ff <= 16'h0000;
        end else if (tick) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    // Capture strobes; compare mode blocks them
    assign cap_a = capctl_ff[`TCU_CAP_A_EN]
                 & (capctl_ff[`TCU_CAP_A_OPP] ? opp_a : edge_b);
    assign cap_b = capctl_ff[`TCU_CAP_B_EN] & edge_a;

    // Capture/compare A: capture beats a software write
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cap_cmp_reg_a_ff <= 16'h0000;
        end else if (cap_a) begin
            cap_cmp_reg_a_ff <= count_ff;
        end else if (wr && paddr_i == `TCU_OFS_CCA) begin
            cap_cmp_reg_a_ff <= pwdata_i[15:0];
        end
    end

    // Capture/compare B: capture beats a software write
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cap_cmp_reg_b_ff <= 16'h0000;
        end else if (cap_b) begin
            cap_cmp_reg_b_ff <= count_ff;
        end else if (wr && paddr_i == `TCU_OFS_CCB) begin
            cap_cmp_reg_b_ff <= pwdata_i[15:0];
        end
    end

    // Interrupt events; opposite-edge capture stays silent and pin B
    // then acts as a plain external interrupt on A
    always_comb begin
        irq_set = 3'h0;
        irq_set[`TCU_IRQ_A] = match_a
            | (capctl_ff[`TCU_CAP_A_EN] & ~capctl_ff[`TCU_CAP_A_OPP]
               & edge_b)
            | (capctl_ff[`TCU_CAP_A_EN] & capctl_ff[`TCU_CAP_A_OPP]
               & edge_b);
        irq_set[`TCU_IRQ_B] = match_b | cap_b;
        irq_set[`TCU_IRQ_OVF] = run & tick & ~clr_cnt
                              & (count_ff == 16'hFFFF);
    end

    // Sticky status, write one to clear; a new event wins the clash
    assign irq_clr = (wr && paddr_i == `TCU_OFS_IRQST) ? pwdata_i[2:0]
                                                       : 3'h0;
    assign nxt_irq_st = irq_set | (irq_st_ff & ~irq_clr);
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            irq_st_ff <= 3'h0;
        end else begin
            irq_st_ff <= nxt_irq_st;
        end
    end
    assign irq_o = |(irq_st_ff & irq_msk_ff);

    // Control registers
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mode_ff    <= 2'h0;
            capctl_ff  <= 3'h0;
            presc_ff   <= 8'h00;
            outctl_ff  <= 3'h0;
            irq_msk_ff <= 3'h0;
        end else if (wr) begin
            unique case (paddr_i)
                `TCU_OFS_MODE:   mode_ff    <= pwdata_i[1:0];
                `TCU_OFS_CAPCTL: capctl_ff  <= pwdata_i[2:0];
                `TCU_OFS_PRESC:  presc_ff   <= pwdata_i[7:0];
                `TCU_OFS_OUTCTL: outctl_ff  <= pwdata_i[2:0];
                `TCU_OFS_IRQMSK: irq_msk_ff <= pwdata_i[2:0];
                default: ;
            endcase
        end
    end

    // Output level: set/reset strobes, toggle on match, or pulse mode
    // high from restart until the B match
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            out_level_ff <= 1'b0;
        end else if (wr && paddr_i == `TCU_OFS_OUTCTL
                     && pwdata_i[`TCU_OUT_LVS]) begin
            out_level_ff <= 1'b1;
        end else if (wr && paddr_i == `TCU_OFS_OUTCTL
                     && pwdata_i[`TCU_OUT_LVR]) begin
            out_level_ff <= 1'b0;
        end else if (ppg_on) begin
            if (match_a) begin
                out_level_ff <= 1'b1;
            end else if (match_b) begin
                out_level_ff <= 1'b0;
            end
        end else if (outctl_ff[`TCU_OUT_MODE_LO] && (match_a || match_b))
        begin
            out_level_ff <= ~out_level_ff;
        end
    end

    // Pin is only driven while the output is enabled
    assign timer_output_pin_o  = out_level_ff & outctl_ff[`TCU_OUT_EN];
    assign timer_output_oe_n_o = ~outctl_ff[`TCU_OUT_EN];

    // Read data captured in the setup cycle, so it comes from a flop
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_ff <= `TCU_RST_WORD;
        end else if (rd_setup) begin
            unique case (paddr_i)
                `TCU_OFS_MODE:   rdata_ff <= {30'h0, mode_ff};
                `TCU_OFS_CAPCTL: rdata_ff <= {29'h0, capctl_ff};
                `TCU_OFS_PRESC:  rdata_ff <= {24'h0, presc_ff};
                `TCU_OFS_OUTCTL: rdata_ff <= {29'h0, outctl_ff};
                `TCU_OFS_COUNT:  rdata_ff <= {16'h0, count_ff};
                `TCU_OFS_CCA:    rdata_ff <= {16'h0, cap_cmp_reg_a_ff};
                `TCU_OFS_CCB:    rdata_ff <= {16'h0, cap_cmp_reg_b_ff};
                `TCU_OFS_IRQST:  rdata_ff <= {29'h0, irq_st_ff};
                `TCU_OFS_IRQMSK: rdata_ff <= {29'h0, irq_msk_ff};
                default:         rdata_ff <= `TCU_RST_WORD;
            endcase
        end
    end
    assign prdata_o = rdata_ff;
endmodule : tcu_timer

// ### verif/tcu_timer_monitor.sv
// Port-level assertions for the timer capture/compare unit
`timescale 1ns/1ns
`include "tcu_map.svh"
module tcu_timer_monitor (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    // APB
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Pins and interrupt
    input wire logic        trigger_pin_a_i,
    input wire logic        trigger_pin_b_i,
    input wire logic        timer_output_pin_o,
    input wire logic        timer_output_oe_n_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Access phase and output-control write decode
    wire logic acc    = psel_i && penable_i;
    wire logic wr_out = acc && pwrite_i && paddr_i == `TCU_OFS_OUTCTL;
    wire logic unmap  = paddr_i > `TCU_OFS_IRQMSK;

    a_ready_high: assert property (psel_i |-> pready_o)
        else $error("ready low during a transfer");
    a_err_setup: assert property (psel_i && !penable_i |-> !pslverr_o)
        else $error("error flagged in setup cycle");
    a_err_unmapped: assert property (acc && unmap |-> pslverr_o)
        else $error("unmapped access not refused");
    a_rdata_zero: assert property (acc && unmap && !pwrite_i |-> !(|prdata_o))
        else $error("unmapped read returned data");
    a_rdata_hold: assert property
        (!(psel_i && !penable_i) |=> $stable(prdata_o))
        else $error("read data moved outside a setup");
    a_oe_by_write: assert property
        ($changed(timer_output_oe_n_o) |-> $past(wr_out))
        else $error("output enable moved without a write");
    a_out_gated: assert property
        (timer_output_oe_n_o |-> !timer_output_pin_o)
        else $error("output high while not driven");
    // Level-set strobe with the enable drives the pin high next cycle
    a_lvs_drive: assert property
        (wr_out && pwdata_i[`TCU_OUT_LVS] && pwdata_i[`TCU_OUT_EN]
         |=> timer_output_pin_o)
        else $error("level set strobe did not drive the pin high");
    a_irq_fall: assert property
        ($fell(irq_o) |-> $past(acc && pwrite_i) || $past(sys_rst_i))
        else $error("interrupt dropped without a write");

    // Main scenarios reached
    c_unmapped: cover property (acc && pslverr_o);
    c_irq: cover property ($rose(irq_o));
    c_drive: cover property ($fell(timer_output_oe_n_o));
endmodule : tcu_timer_monitor

bind tcu_timer tcu_timer_monitor mon (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .trigger_pin_a_i(trigger_pin_a_i),
    .trigger_pin_b_i(trigger_pin_b_i), .irq_o(irq_o),
    .timer_output_pin_o(timer_output_pin_o),
    .timer_output_oe_n_o(timer_output_oe_n_o));

// ### verif/tcu_pin_model.sv
// Pin-side partner: drives both trigger pins, shares pin B with output
`timescale 1ns/1ns
module tcu_pin_model (
    // Clock
    input  wire logic clock_i,
    // Timer side of the shared pin
    input  wire logic timer_output_pin_i,
    input  wire logic timer_output_oe_n_i,
    // Trigger pins
    output logic      trigger_pin_a_o,
    output logic      trigger_pin_b_o
);
    logic pin_a_ff = 1'b0;
    logic pin_b_ff = 1'b0;
    // Timer owns the shared pin while driving; our source steps back
    assign trigger_pin_b_o = timer_output_oe_n_i ? pin_b_ff
                                                 : timer_output_pin_i;
    assign trigger_pin_a_o = pin_a_ff;
    // Levels move just after an edge
    task automatic set_pin(input logic sel, input logic lvl);
        @(posedge clock_i);
        if (sel)
            pin_b_ff <= lvl;
        else
            pin_a_ff <= lvl;
    endtask : set_pin
    // Six cycles covers a /2 count period plus four
    task automatic pulse(input logic sel);
        set_pin(sel, 1'b1);
        repeat (6) @(posedge clock_i);
        set_pin(sel, 1'b0);
        repeat (6) @(posedge clock_i);
    endtask : pulse
endmodule : tcu_pin_model

// ### verif/tb_timer_capture_compare_unit.sv
// Self-checking bench for the timer capture/compare unit
`timescale 1ns/1ns
`include "tcu_map.svh"
module tb_timer_capture_compare_unit;
    logic        clock_i   = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0;
    logic [31:0] prdata_o, rd_q;
    logic        pready_o, pslverr_o, pin_a, pin_b, tout, toe_n, irq_o;
    logic        rd_err;
    int          err_count = 0;
    int          cmp_count = 0;
    // 100 ns period
    always #50 clock_i = ~clock_i;

    tcu_timer dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .trigger_pin_a_i(pin_a), .trigger_pin_b_i(pin_b),
        .timer_output_pin_o(tout), .timer_output_oe_n_o(toe_n),
        .irq_o(irq_o));
    tcu_pin_model pins (.clock_i(clock_i), .timer_output_pin_i(tout),
        .timer_output_oe_n_i(toe_n), .trigger_pin_a_o(pin_a),
        .trigger_pin_b_o(pin_b));

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clock_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            results();
        end
        rd_q   = prdata_o;
        rd_err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, rd_q & m, exp);
    endtask : rd_chk
    // Interrupt looked at mid-cycle, once the status flop has settled
    task automatic chk_irq(input logic exp);
        @(negedge clock_i);
        check("irq", {31'h0, irq_o}, {31'h0, exp});
    endtask : chk_irq
    task automatic wait_out(input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (tout !== lvl && n < 200);
        if (n >= 200) begin
            err_count++;
            results();
        end
    endtask : wait_out

    task automatic t_reset();
        rd_chk(`TCU_OFS_MODE, 32'hFFFF_FFFF, 32'h0, "mode");
        rd_chk(`TCU_OFS_IRQST, 32'hFFFF_FFFF, 32'h0, "irq status");
        check("output enable", {31'h0, toe_n}, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", {31'h0, rd_err}, 32'h1);
        check("unmapped data", rd_q, 32'h0);
        $display("test reset done");
    endtask : t_reset
    // Pin A already high at the very first start, then at a restart
    task automatic t_first_start();
        pins.set_pin(1'b0, 1'b1);
        wr(`TCU_OFS_PRESC, 32'h10);
        wr(`TCU_OFS_CAPCTL, 32'h4);
        wr(`TCU_OFS_IRQMSK, 32'h2);
        wr(`TCU_OFS_MODE, 32'h1);
        repeat (4) @(posedge clock_i);
        rd_chk(`TCU_OFS_IRQST, 32'h2, 32'h2, "first start");
        chk_irq(1'b1);
        wr(`TCU_OFS_IRQST, 32'h2);
        chk_irq(1'b0);
        wr(`TCU_OFS_MODE, 32'h0);
        wr(`TCU_OFS_MODE, 32'h1);
        repeat (4) @(posedge clock_i);
        rd_chk(`TCU_OFS_IRQST, 32'h2, 32'h0, "restart");
        wr(`TCU_OFS_MODE, 32'h0);
        pins.set_pin(1'b0, 1'b0);
        $display("test first start done");
    endtask : t_first_start
    task automatic t_count();
        repeat (10) @(posedge clock_i);
        rd_chk(`TCU_OFS_COUNT, 32'hFFFF, 32'h0, "stopped count");
        wr(`TCU_OFS_MODE, 32'h1);
        repeat (20) @(posedge clock_i);
        apb(1'b0, `TCU_OFS_COUNT, 32'h0);
        check("running", {31'h0, rd_q[15:0] != 16'h0}, 32'h1);
        wr(`TCU_OFS_MODE, 32'h0);
        rd_chk(`TCU_OFS_COUNT, 32'hFFFF, 32'h0, "stop clears");
        $display("test count done");
    endtask : t_count
    task automatic t_compare();
        wr(`TCU_OFS_CAPCTL, 32'h0);
        wr(`TCU_OFS_PRESC, 32'h50);
        wr(`TCU_OFS_CCA, 32'h1234);
        wr(`TCU_OFS_CCB, 32'h5678);
        wr(`TCU_OFS_MODE, 32'h1);
        pins.pulse(1'b0);
        pins.pulse(1'b1);
        rd_chk(`TCU_OFS_CCA, 32'hFFFF, 32'h1234, "cca kept");
        rd_chk(`TCU_OFS_CCB, 32'hFFFF, 32'h5678, "ccb kept");
        wr(`TCU_OFS_MODE, 32'h0);
        wr(`TCU_OFS_IRQST, 32'h7);
        $display("test compare done");
    endtask : t_compare
    // Capture on pin A falling edge; pin B only interrupts
    task automatic t_opposite();
        logic [31:0] cap;
        wr(`TCU_OFS_CCA, 32'h0);
        wr(`TCU_OFS_CAPCTL, 32'h3);
        wr(`TCU_OFS_IRQMSK, 32'h0);
        wr(`TCU_OFS_MODE, 32'h1);
        repeat (10) @(posedge clock_i);
        pins.pulse(1'b0);
        apb(1'b0, `TCU_OFS_CCA, 32'h0);
        cap = rd_q & 32'hFFFF;
        check("captured", {31'h0, cap != 32'h0}, 32'h1);
        rd_chk(`TCU_OFS_IRQST, 32'h1, 32'h0, "no irq");
        pins.pulse(1'b1);
        rd_chk(`TCU_OFS_IRQST, 32'h1, 32'h1, "ext irq");
        rd_chk(`TCU_OFS_CCA, 32'hFFFF, cap, "no b capture");
        chk_irq(1'b0);
        wr(`TCU_OFS_IRQMSK, 32'h1);
        chk_irq(1'b1);
        wr(`TCU_OFS_IRQST, 32'h1);
        chk_irq(1'b0);
        wr(`TCU_OFS_MODE, 32'h0);
        $display("test opposite edge done");
    endtask : t_opposite
    // Pulse mode: period (CCA+1) ticks of two cycles, width from CCB
    task automatic t_pulse();
        int n, hi, lo;
        wr(`TCU_OFS_CAPCTL, 32'h0);
        wr(`TCU_OFS_PRESC, 32'hA0);
        wr(`TCU_OFS_CCA, 32'h9);
        wr(`TCU_OFS_CCB, 32'h3);
        wr(`TCU_OFS_OUTCTL, 32'h6);
        wr(`TCU_OFS_OUTCTL, 32'h7);
        wr(`TCU_OFS_OUTCTL, 32'hF);
        check("output driven", {31'h0, toe_n}, 32'h0);
        wr(`TCU_OFS_MODE, 32'h3);
        wait_out(1'b0, n);
        wait_out(1'b1, n);
        wait_out(1'b0, hi);
        wait_out(1'b1, lo);
        check("period", hi + lo, 32'd20);
        // High from the A match through counts 0..3, four ticks of two
        check("width", hi, 32'd8);
        wr(`TCU_OFS_MODE, 32'h0);
        wr(`TCU_OFS_OUTCTL, 32'h0);
        $display("test pulse done");
    endtask : t_pulse

    // Pin A edges as the count clock, then clear on a pin A edge
    task automatic t_event();
        wr(`TCU_OFS_PRESC, 32'h13);
        wr(`TCU_OFS_MODE, 32'h1);
        repeat (3) pins.pulse(1'b0);
        rd_chk(`TCU_OFS_COUNT, 32'hFFFF, 32'h3, "pin a events");
        wr(`TCU_OFS_MODE, 32'h0);
        wr(`TCU_OFS_PRESC, 32'h11);
        wr(`TCU_OFS_MODE, 32'h2);
        repeat (60) @(posedge clock_i);
        // A /8 count period needs a pulse of at least ten cycles
        pins.set_pin(1'b0, 1'b1);
        repeat (12) @(posedge clock_i);
        pins.set_pin(1'b0, 1'b0);
        rd_chk(`TCU_OFS_COUNT, 32'hFFF8, 32'h0, "pin a clear");
        wr(`TCU_OFS_MODE, 32'h0);
        $display("test event count done");
    endtask : t_event

    // Main sequence
    initial begin
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_first_start();
        t_count();
        t_compare();
        t_opposite();
        t_pulse();
        t_event();
        results();
    end
endmodule : tb_timer_capture_compare_unit
